// ### shared/sddc_defines.svh
// Address map, field positions, reset values and timing counts of the DAC core.
`ifndef SDDC_DEFINES_SVH
`define SDDC_DEFINES_SVH
`define SDDC_ADDR_CTRL 8'h00
`define SDDC_ADDR_STATUS 8'h04
`define SDDC_ADDR_PERIOD 8'h08
`define SDDC_ADDR_LEFT 8'h0C
`define SDDC_ADDR_RIGHT 8'h10
`define SDDC_CTRL_MUTE 0
`define SDDC_CTRL_RST 1'b0
`define SDDC_ST_LOCKED 0
`define SDDC_ST_SLEEP 1
`define SDDC_ST_MUTED 2
`define SDDC_ST_DEEMPH 3
`define SDDC_RESP_OKAY 2'b00
`define SDDC_RESP_SLVERR 2'b10
`define SDDC_BITS_18 5'h12
`define SDDC_BITS_16 5'h10
`define SDDC_OSR_LOG2 7
`define SDDC_PH_LAST 7'h7F
`define SDDC_TICK_HALF 28'h0004000
`define SDDC_PLL_FRAC 8
`define SDDC_PLL_FAST_SHIFT 2
`define SDDC_PLL_SLOW_SHIFT 9
`define SDDC_LOCK_TIGHT 6
`define SDDC_LOCK_LOOSE 3
`define SDDC_LOCK_FRAMES 5'h10
`define SDDC_DROOP_SHIFT 4
`define SDDC_HB_SHIFT 4
`define SDDC_COMB_LOG2 5
`define SDDC_Q_SHIFT 14
`define SDDC_Q_MAX 8
`define SDDC_LEVEL_MID 5'h08
`define SDDC_LEVEL_MAX 5'h10
`endif

// ### shared/sddc_pkg.sv
// Types shared by the DAC core.
package sddc_pkg;
	typedef enum logic {PLL_ACQUIRE, PLL_TRACK} sddc_pll_e;
	typedef logic signed [21:0] sddc_acc_t;
	typedef logic signed [17:0] sddc_sample_t;
	typedef logic [4:0] sddc_level_t;
endpackage

// ### rtl/sddc_core.sv
// Digital core of a stereo multibit sigma-delta audio DAC.
//------------------------------------------------------------
// Overview of operation
// R1 - Sleep-reset pin held low keeps the core asleep and quiet.
// R2 - Rising sleep-reset pin restarts the core with default register values.
// R3 - De-emphasis pin high closes both de-emphasis switches, low opens them; the code holds both switches open while the sleep-reset pin is low.
// R4 - Mute pin high silences both channels; low resumes playback.
// R5 - Bit clock only shifts serial data in; may be asynchronous to frame clock.
// R6 - Frame clock frames channels and is the reference the PLL tracks.
// R7 - Audio words travel MSB first in two's complement.
// R8 - Input words are 16 or 18 bits per channel.
// R9 - First-order PLL loop, about 15 Hz bandwidth once tracking.
// R10 - Interpolation ratio follows the measured input sample rate.
// R11 - Interpolator is droop equalizer, two half-band stages, second-order comb.
// R12 - Interpolator uses shifts and adds only, no multipliers.
// R13 - Four-bit sigma-delta modulator output takes one of 17 levels.
// R14 - Modulator runs at nominally 128 times the input sample rate.
// R15 - Left channel field comes before right channel field.
// R16 - Source keeps frame clock running; bit clock may be gated.
// R17 - Captured samples cross into the master domain by synchronized handoff.
// R18 - Mute zeroes modulator input on both channels without touching the PLL.
//------------------------------------------------------------
//
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "sddc_defines.svh"

module sddc_core (
	// Master clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Serial audio link
	input wire logic bit_clk,
	input wire logic frame_clk,
	input wire logic serial_audio_in,
	input wire logic word_18,
	// Control pins
	input wire logic sleep_reset_n,
	input wire logic deemph_enable,
	input wire logic mute,
	// Modulator and analog switch outputs
	output logic [4:0] mod_level_l,
	output logic [4:0] mod_level_r,
	output logic mod_strobe,
	output logic deemph_switch_l,
	output logic deemph_switch_r,
	output logic sleeping,
	// AXI4-Lite register slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	//------------------------------------------------------------
	// Link domain: serial capture on the bit clock
	//------------------------------------------------------------
	// Frame clock and data share one three-stage pipeline so their
	// alignment survives even when the two are not phase related.
	logic [2:0] lrst_s, w18_s, lr_s, sd_s;
	logic lrst, w18, lr_q, frame_tg;
	logic next_w18, next_lr_q, next_tg;
	logic [17:0] sh, next_sh;
	logic [4:0] cnt, next_cnt, wlen;
	sddc_pkg::sddc_sample_t left_w, right_w, next_left, next_right;

	function automatic sddc_pkg::sddc_sample_t align(input logic [17:0] s, input logic b18);
		align = b18 ? s : {s[15:0], 2'h0}; // R8
	endfunction

	assign lrst = ~(lrst_s[1] | lrst_s[2]);
	assign wlen = w18 ? `SDDC_BITS_18 : `SDDC_BITS_16;

	always_comb begin
		next_w18 = (w18_s[1] == w18_s[2]) ? w18_s[2] : w18;
		next_lr_q = lr_q;
		next_sh = sh;
		next_cnt = cnt;
		next_left = left_w;
		next_right = right_w;
		next_tg = frame_tg;
		if (lr_s[1] == lr_s[2] && lr_s[2] != lr_q) begin
			// Left-justified: the MSB sits on the frame edge. R7
			next_lr_q = lr_s[2];
			next_sh = {sh[16:0], sd_s[2]};
			next_cnt = 5'h01;
			if (lr_s[2]) begin
				// A new left field closes the stereo pair. R15
				next_right = align(sh, w18);
				next_tg = ~frame_tg;
			end else begin
				next_left = align(sh, w18);
			end
		end else if (cnt < wlen) begin
			next_sh = {sh[16:0], sd_s[2]}; // R5
			next_cnt = cnt + 5'h01;
		end
	end

	always_ff @(posedge bit_clk) begin
		lrst_s <= {lrst_s[1:0], rst_n};
		w18_s <= {w18_s[1:0], word_18};
		lr_s <= {lr_s[1:0], frame_clk};
		sd_s <= {sd_s[1:0], serial_audio_in};
		if (lrst) begin
			w18 <= 1'b0;
			lr_q <= 1'b0;
			sh <= 18'h00000;
			cnt <= 5'h00;
			left_w <= 18'sh00000;
			right_w <= 18'sh00000;
			frame_tg <= 1'b0;
		end else begin
			w18 <= next_w18;
			lr_q <= next_lr_q;
			sh <= next_sh;
			cnt <= next_cnt;
			left_w <= next_left;
			right_w <= next_right;
			frame_tg <= next_tg;
		end
	end

	//------------------------------------------------------------
	// Pin synchronisers in the master domain
	//------------------------------------------------------------
	// Bit order: 0 frame clock, 1 sleep-reset, 2 mute, 3 de-emphasis.
	logic [3:0] p1, p2, p3, pin_st;
	logic [2:0] tg_s;
	logic tg_seen, frame_evt, core_rst, mute_eff;
	logic ctrl_mute;

	assign frame_evt = (tg_s[1] == tg_s[2]) && (tg_s[2] != tg_seen);
	assign core_rst = ~rst_n | ~pin_st[1]; // R1 R2
	assign mute_eff = pin_st[2] | ctrl_mute; // R4

	always_ff @(posedge ref_clk) begin
		p1 <= {deemph_enable, mute, sleep_reset_n, frame_clk};
		p2 <= p1;
		p3 <= p2;
		tg_s <= {tg_s[1:0], frame_tg};
		if (!rst_n) begin
			pin_st <= 4'h0;
			tg_seen <= 1'b0;
		end else begin
			pin_st <= (p2 & p3) | (pin_st & (p2 | p3));
			tg_seen <= frame_evt ? tg_s[2] : tg_seen;
		end
	end

	//------------------------------------------------------------
	// Sample handoff
	//------------------------------------------------------------
	// The link words stay frozen for at least half a frame after the toggle,
	// far longer than the three-stage toggle sync takes to settle.
	sddc_pkg::sddc_sample_t in_l, in_r, next_in_l, next_in_r;

	always_comb begin
		next_in_l = frame_evt ? left_w : in_l; // R17
		next_in_r = frame_evt ? right_w : in_r;
	end

	always_ff @(posedge ref_clk) begin
		if (core_rst) begin
			in_l <= 18'sh00000;
			in_r <= 18'sh00000;
		end else begin
			in_l <= next_in_l;
			in_r <= next_in_r;
		end
	end

	//------------------------------------------------------------
	// Digital PLL on the frame clock
	//------------------------------------------------------------
	sddc_pkg::sddc_pll_e pll, next_pll;
	logic [19:0] per_cnt, next_per_cnt;
	logic [27:0] est, next_est;
	logic [4:0] lock_cnt, next_lock_cnt;
	logic lr_prev, lr_rise;
	logic signed [28:0] err;
	logic [27:0] aerr;

	assign lr_rise = pin_st[0] & ~lr_prev;
	assign err = $signed({1'b0, per_cnt, 8'h00}) - $signed({1'b0, est});
	assign aerr = err[28] ? 28'(-err) : err[27:0];

	always_comb begin
		next_pll = pll;
		next_est = est;
		next_lock_cnt = lock_cnt;
		next_per_cnt = per_cnt + 20'h00001;
		if (lr_rise) begin
			next_per_cnt = 20'h00001;
			if (est == 28'h0) begin
				next_est = {per_cnt, 8'h00};
			end else if (pll == sddc_pkg::PLL_TRACK) begin
				// Narrow first-order loop rejects frame jitter. R9
				next_est = 28'($signed({1'b0, est}) + (err >>> `SDDC_PLL_SLOW_SHIFT));
			end else begin
				next_est = 28'($signed({1'b0, est}) + (err >>> `SDDC_PLL_FAST_SHIFT));
			end
			if (aerr > (est >> `SDDC_LOCK_LOOSE)) begin
				next_pll = sddc_pkg::PLL_ACQUIRE;
				next_lock_cnt = 5'h00;
			end else if (aerr <= (est >> `SDDC_LOCK_TIGHT)) begin
				case (pll)
					sddc_pkg::PLL_ACQUIRE: begin
						next_lock_cnt = lock_cnt + 5'h01;
						if (lock_cnt == `SDDC_LOCK_FRAMES) begin
							next_pll = sddc_pkg::PLL_TRACK; // R6
						end
					end
					default: next_lock_cnt = lock_cnt;
				endcase
			end
		end
	end

	// The PLL is reset only by the bus reset and sleep; mute leaves it alone. R18
	always_ff @(posedge ref_clk) begin
		if (core_rst) begin
			pll <= sddc_pkg::PLL_ACQUIRE;
			est <= 28'h0;
			lock_cnt <= 5'h00;
			per_cnt <= 20'h00000;
			lr_prev <= 1'b0;
		end else begin
			pll <= next_pll;
			est <= next_est;
			lock_cnt <= next_lock_cnt;
			per_cnt <= next_per_cnt;
			lr_prev <= pin_st[0];
		end
	end

	//------------------------------------------------------------
	// Oversampling tick: 128 ticks per estimated frame period
	//------------------------------------------------------------
	logic [19:0] tick_cnt, next_tick_cnt, tick_gap;
	logic [6:0] ph, next_ph;
	logic tick;

	// Rounded, not truncated: the loop can settle a few fraction steps
	// below the true period, and a truncated gap would then tick too fast. R10 R14
	assign tick_gap = 20'((est + `SDDC_TICK_HALF) >> (`SDDC_PLL_FRAC + `SDDC_OSR_LOG2));
	assign tick = (tick_cnt >= tick_gap) && (tick_gap != 20'h0);

	always_comb begin
		next_tick_cnt = tick ? 20'h00001 : tick_cnt + 20'h00001;
		next_ph = tick ? ph + 7'h01 : ph;
	end

	always_ff @(posedge ref_clk) begin
		if (core_rst) begin
			tick_cnt <= 20'h00000;
			ph <= 7'h00;
		end else begin
			tick_cnt <= next_tick_cnt;
			ph <= next_ph;
		end
	end

	//------------------------------------------------------------
	// Interpolator and modulator, one instance per channel
	//------------------------------------------------------------
	// Half-band interpolation tap: (9(b+c) - (a+d)) / 16, shifts and adds.
	function automatic sddc_pkg::sddc_acc_t hb_mid(input sddc_pkg::sddc_acc_t a,
		input sddc_pkg::sddc_acc_t b, input sddc_pkg::sddc_acc_t c,
		input sddc_pkg::sddc_acc_t d);
		logic signed [25:0] s;
		s = 26'(b + c);
		s = (s <<< 3) + s - 26'(a + d); // R12
		hb_mid = 22'(s >>> `SDDC_HB_SHIFT);
	endfunction

	sddc_pkg::sddc_level_t lvl [2];

	for (genvar c = 0; c < 2; c++) begin : g_ch
		sddc_pkg::sddc_acc_t x, eq, h1 [4], h2 [4], h1_out, h2_out, cmb_a, slope, acc, e;
		sddc_pkg::sddc_acc_t x1, x2, next_x1, next_x2, next_eq, next_acc, next_e, next_cmb_a;
		sddc_pkg::sddc_acc_t next_slope, u, qv, mod_in;
		sddc_pkg::sddc_acc_t next_h1 [4], next_h2 [4];
		logic signed [7:0] q;
		sddc_pkg::sddc_level_t next_lvl;

		assign x = 22'(c == 0 ? in_l : in_r);
		// R11: equalizer, half-band, half-band, then a 32x second-order comb.
		assign h1_out = ph[6] ? hb_mid(h1[0], h1[1], h1[2], h1[3]) : h1[2];
		assign h2_out = ph[5] ? hb_mid(h2[0], h2[1], h2[2], h2[3]) : h2[2];
		assign mod_in = mute_eff ? 22'sh000000 : acc; // R4 R18

		always_comb begin
			next_x1 = x1;
			next_x2 = x2;
			next_eq = eq;
			next_h1 = h1;
			next_h2 = h2;
			next_cmb_a = cmb_a;
			next_slope = slope;
			next_acc = acc;
			next_e = e;
			next_lvl = lvl[c];
			u = mod_in + e;
			q = 8'(u >>> `SDDC_Q_SHIFT);
			if (q > `SDDC_Q_MAX) q = 8'(`SDDC_Q_MAX);
			if (q < -`SDDC_Q_MAX) q = 8'(-`SDDC_Q_MAX);
			qv = 22'(q) <<< `SDDC_Q_SHIFT;
			if (tick) begin
				if (ph == 7'h00) begin
					next_x1 = x;
					next_x2 = x1;
					next_eq = x1 + ((((x1 <<< 1) - x) - x2) >>> `SDDC_DROOP_SHIFT); // R12
					next_h1 = '{eq, h1[0], h1[1], h1[2]};
				end
				if (ph[5:0] == 6'h00) begin
					next_h2 = '{h1_out, h2[0], h2[1], h2[2]};
				end
				if (ph[4:0] == 5'h00) begin
					next_cmb_a = h2_out;
					next_slope = (h2_out - cmb_a) >>> `SDDC_COMB_LOG2;
					next_acc = cmb_a;
				end else begin
					next_acc = acc + slope;
				end
				// First-order error feedback around a 17-level quantizer. R13
				next_e = u - qv;
				next_lvl = 5'(q + 8'sd8);
			end
		end

		always_ff @(posedge ref_clk) begin
			if (core_rst) begin
				x1 <= '0;
				x2 <= '0;
				eq <= '0;
				h1 <= '{default: '0};
				h2 <= '{default: '0};
				cmb_a <= '0;
				slope <= '0;
				acc <= '0;
				e <= '0;
				lvl[c] <= `SDDC_LEVEL_MID; // R1
			end else begin
				x1 <= next_x1;
				x2 <= next_x2;
				eq <= next_eq;
				h1 <= next_h1;
				h2 <= next_h2;
				cmb_a <= next_cmb_a;
				slope <= next_slope;
				acc <= next_acc;
				e <= next_e;
				lvl[c] <= next_lvl;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mod_level_l <= `SDDC_LEVEL_MID;
			mod_level_r <= `SDDC_LEVEL_MID;
			mod_strobe <= 1'b0;
			deemph_switch_l <= 1'b0;
			deemph_switch_r <= 1'b0;
			sleeping <= 1'b1;
		end else begin
			mod_level_l <= lvl[0];
			mod_level_r <= lvl[1];
			mod_strobe <= tick & ~core_rst;
			deemph_switch_l <= pin_st[3] & pin_st[1]; // R3
			deemph_switch_r <= pin_st[3] & pin_st[1];
			sleeping <= ~pin_st[1]; // R1
		end
	end

	//------------------------------------------------------------
	// AXI4-Lite slave
	//------------------------------------------------------------
	logic aw_ok, w_ok, next_aw_ok, next_w_ok, next_ctrl_mute;
	logic [7:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data, next_rdata;
	logic w_b0, next_w_b0, next_bvalid, next_rvalid;
	logic [1:0] next_bresp, next_rresp;

	function automatic logic [2:0] reg_index(input logic [7:0] a);
		case (a)
			`SDDC_ADDR_CTRL: reg_index = 3'h0;
			`SDDC_ADDR_STATUS: reg_index = 3'h1;
			`SDDC_ADDR_PERIOD: reg_index = 3'h2;
			`SDDC_ADDR_LEFT: reg_index = 3'h3;
			`SDDC_ADDR_RIGHT: reg_index = 3'h4;
			default: reg_index = 3'h7;
		endcase
	endfunction

	always_comb begin
		next_aw_ok = aw_ok;
		next_aw_addr = aw_addr;
		next_w_ok = w_ok;
		next_w_data = w_data;
		next_w_b0 = w_b0;
		next_bvalid = s_axi_bvalid && !s_axi_bready;
		next_bresp = s_axi_bresp;
		next_ctrl_mute = ctrl_mute;
		next_rvalid = s_axi_rvalid && !s_axi_rready;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_ok = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_ok = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_b0 = s_axi_wstrb[0];
		end
		if (aw_ok && w_ok && !s_axi_bvalid) begin
			next_aw_ok = 1'b0;
			next_w_ok = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = `SDDC_RESP_SLVERR;
			if (reg_index(aw_addr) == 3'h0) begin
				next_bresp = `SDDC_RESP_OKAY;
				if (w_b0) next_ctrl_mute = w_data[`SDDC_CTRL_MUTE];
			end else if (reg_index(aw_addr) != 3'h7) begin
				next_bresp = `SDDC_RESP_OKAY;
			end
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp = `SDDC_RESP_OKAY;
			next_rdata = 32'h0;
			case (reg_index(s_axi_araddr))
				3'h0: next_rdata[`SDDC_CTRL_MUTE] = ctrl_mute;
				3'h1: begin
					next_rdata[`SDDC_ST_LOCKED] = (pll == sddc_pkg::PLL_TRACK);
					next_rdata[`SDDC_ST_SLEEP] = ~pin_st[1];
					next_rdata[`SDDC_ST_MUTED] = mute_eff;
					next_rdata[`SDDC_ST_DEEMPH] = pin_st[3];
				end
				3'h2: next_rdata = {4'h0, est};
				3'h3: next_rdata = 32'(in_l);
				3'h4: next_rdata = 32'(in_r);
				default: next_rresp = `SDDC_RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			aw_ok <= 1'b0;
			aw_addr <= 8'h00;
			w_ok <= 1'b0;
			w_data <= 32'h0;
			w_b0 <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SDDC_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `SDDC_RESP_OKAY;
		end else begin
			aw_ok <= next_aw_ok;
			aw_addr <= next_aw_addr;
			w_ok <= next_w_ok;
			w_data <= next_w_data;
			w_b0 <= next_w_b0;
			s_axi_awready <= ~next_aw_ok;
			s_axi_wready <= ~next_w_ok;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_arready <= ~next_rvalid;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end

	// Control register falls back to its default in sleep. R2
	always_ff @(posedge ref_clk) begin
		if (core_rst) begin
			ctrl_mute <= `SDDC_CTRL_RST;
		end else begin
			ctrl_mute <= next_ctrl_mute;
		end
	end

	//------------------------------------------------------------
	// Assertions
	//------------------------------------------------------------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	a_sleep_mid_level: assert property (!pin_st[1] ##1 !pin_st[1] |=> // R1
		mod_level_l == `SDDC_LEVEL_MID && mod_level_r == `SDDC_LEVEL_MID)
		else $error("levels not idle in sleep");
	a_wake_ctrl_default: assert property ($rose(pin_st[1]) |-> !ctrl_mute) // R2
		else $error("control not default after wake");
	a_deemph_follow: assert property (pin_st[3] && pin_st[1] |=> deemph_switch_l) // R3
		else $error("de-emphasis switch open");
	a_mute_zero_in: assert property (pin_st[2] |-> g_ch[0].mod_in == 0 && g_ch[1].mod_in == 0) // R4
		else $error("mute did not zero data");
	a_mute_keeps_pll: assert property (pin_st[2] && pll == sddc_pkg::PLL_TRACK && pin_st[1] // R18
		&& !lr_rise |=> pll == sddc_pkg::PLL_TRACK)
		else $error("mute disturbed pll");
	a_lock_needs_run: assert property ($rose(pll == sddc_pkg::PLL_TRACK) |-> // R6
		$past(lock_cnt) == `SDDC_LOCK_FRAMES)
		else $error("pll tracked too early");
	a_level_range: assert property (mod_strobe |-> mod_level_l <= `SDDC_LEVEL_MAX // R13
		&& mod_level_r <= `SDDC_LEVEL_MAX)
		else $error("level beyond 17 steps");
	a_phase_wrap: assert property (tick && ph == `SDDC_PH_LAST && !core_rst |=> ph == 7'h00) // R14
		else $error("oversample phase wrap");
	a_handoff_take: assert property (frame_evt && !core_rst |=> in_l == $past(left_w)) // R17
		else $error("handoff lost sample");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");

endmodule
`default_nettype wire

// ### bench/sddc_src.sv
// Behavioural serial audio source that feeds the DAC core.
`timescale 1ns/100ps
`default_nettype none

module sddc_src (
	// Words to send
	input wire logic word_18,
	input wire logic [17:0] left_word,
	input wire logic [17:0] right_word,
	// Serial link
	output logic bit_clk,
	output logic frame_clk,
	output logic serial_audio_in
);
	int nb;
	logic [17:0] w;

	initial begin
		bit_clk = 1'b0;
		frame_clk = 1'b0;
		serial_audio_in = 1'b0;
		#3;
		forever begin
			for (int h = 0; h < 2; h++) begin
				frame_clk = (h == 0);
				w = (h == 0) ? left_word : right_word;
				nb = word_18 ? 18 : 16;
				for (int i = 0; i < nb; i++) begin
					serial_audio_in = w[17 - i];
					#16 bit_clk = 1'b1;
					#16 bit_clk = 1'b0;
				end
				// The line is not held after the word, so it must not be read.
				serial_audio_in = ~serial_audio_in;
				#(32 * (32 - nb));
			end
		end
	end
endmodule
`default_nettype wire

// ### bench/sddc_core_test.sv
// Self-checking bench for the stereo DAC core.
`timescale 1ns/100ps
`default_nettype none
`include "sddc_defines.svh"

module sddc_core_test;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic word_18 = 1'b1;
	logic sleep_reset_n = 1'b1;
	logic deemph_enable = 1'b0;
	logic mute = 1'b0;
	logic [17:0] left_word = 18'h2ABCD;
	logic [17:0] right_word = 18'h15432;
	wire logic bit_clk;
	wire logic frame_clk;
	wire logic serial_audio_in;
	logic [4:0] mod_level_l;
	logic [4:0] mod_level_r;
	logic mod_strobe;
	logic deemph_switch_l;
	logic deemph_switch_r;
	logic sleeping;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b0;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	int errors = 0;
	int compares = 0;
	int strobes = 0;
	logic lvl_bad = 1'b0;

	always #2 ref_clk = ~ref_clk;

	sddc_src sddc_src_i (.word_18, .left_word, .right_word, .bit_clk, .frame_clk,
		.serial_audio_in);

	sddc_core sddc_core_i (.ref_clk, .rst_n, .bit_clk, .frame_clk, .serial_audio_in,
		.word_18, .sleep_reset_n, .deemph_enable, .mute, .mod_level_l, .mod_level_r,
		.mod_strobe, .deemph_switch_l, .deemph_switch_r, .sleeping, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);

	always @(posedge ref_clk) begin
		if (mod_strobe === 1'b1) strobes++;
		if (mod_level_l > 5'h10 || mod_level_r > 5'h10) lvl_bad = 1'b1;
	end

	//------------------------------------------------------------
	// Checks and bus tasks
	//------------------------------------------------------------
	task automatic print_verdict();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic hang(input string nm);
		errors++;
		$display("MISMATCH %s expected answer seen timeout", nm);
		print_verdict();
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 50);
		if (s_axi_bvalid !== 1'b1) hang("write");
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 50);
		if (s_axi_rvalid !== 1'b1) hang("read");
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	//------------------------------------------------------------
	// Main sequence
	//------------------------------------------------------------
	initial begin
		logic [31:0] rd;
		logic [1:0] rs;
		int n;
		int s0;
		logic bad;
		// Held past four link clock edges, which the capture side needs too.
		repeat (40) @(posedge ref_clk);
		chk("level in reset", 32'h8, {27'h0, mod_level_l});
		chk("sleeping in reset", 32'h1, {31'h0, sleeping});
		rst_n <= 1'b1;
		axi_rd(`SDDC_ADDR_CTRL, rd, rs);
		chk("ctrl default", 32'h0, rd);
		axi_wr(`SDDC_ADDR_CTRL, 32'h1, rs);
		chk("ctrl write resp", 32'h0, {30'h0, rs});
		axi_rd(`SDDC_ADDR_STATUS, rd, rs);
		chk("soft mute", 32'h1, {31'h0, rd[`SDDC_ST_MUTED]});
		axi_wr(8'h14, 32'h0, rs);
		chk("unmapped write", 32'h2, {30'h0, rs});
		axi_rd(8'h14, rd, rs);
		chk("unmapped read", 32'h2, {30'h0, rs});
		chk("unmapped data", 32'h0, rd);
		axi_wr(`SDDC_ADDR_STATUS, 32'hFFFFFFFF, rs);
		chk("read-only write", 32'h0, {30'h0, rs});
		axi_rd(`SDDC_ADDR_CTRL, rd, rs);
		chk("ctrl kept", 32'h1, rd);
		axi_wr(`SDDC_ADDR_CTRL, 32'h0, rs);
		n = 0;
		do begin
			axi_rd(`SDDC_ADDR_STATUS, rd, rs);
			n++;
		end while (rd[`SDDC_ST_LOCKED] !== 1'b1 && n < 6000);
		if (rd[`SDDC_ST_LOCKED] !== 1'b1) hang("pll tracking");
		// Frame is 2048 ns, so 512 master cycles with eight fraction bits.
		axi_rd(`SDDC_ADDR_PERIOD, rd, rs);
		chk("period", 32'h1, {31'h0, rd > 32'h1F800 && rd < 32'h20800});
		axi_rd(`SDDC_ADDR_LEFT, rd, rs);
		chk("left 18", 32'hFFFEABCD, rd);
		axi_rd(`SDDC_ADDR_RIGHT, rd, rs);
		chk("right 18", 32'h00015432, rd);
		s0 = strobes;
		repeat (2048) @(posedge ref_clk);
		chk("tick count", 32'h1, {31'h0, strobes - s0 > 507 && strobes - s0 < 517});
		word_18 <= 1'b0;
		left_word <= {16'h8001, 2'b00};
		right_word <= {16'h7FFE, 2'b00};
		repeat (2600) @(posedge ref_clk);
		axi_rd(`SDDC_ADDR_LEFT, rd, rs);
		chk("left 16", 32'hFFFE0004, rd);
		axi_rd(`SDDC_ADDR_RIGHT, rd, rs);
		chk("right 16", 32'h0001FFF8, rd);
		mute <= 1'b1;
		repeat (64) @(posedge ref_clk);
		bad = 1'b0;
		repeat (256) begin
			@(posedge ref_clk);
			if (mod_level_l < 5'h07 || mod_level_l > 5'h09) bad = 1'b1;
			if (mod_level_r < 5'h07 || mod_level_r > 5'h09) bad = 1'b1;
		end
		chk("muted levels", 32'h0, {31'h0, bad});
		axi_rd(`SDDC_ADDR_STATUS, rd, rs);
		chk("mute keeps lock", 32'h5, {28'h0, rd[3:0] & 4'h5});
		mute <= 1'b0;
		deemph_enable <= 1'b1;
		repeat (8) @(posedge ref_clk);
		chk("deemph on", 32'h3, {30'h0, deemph_switch_l, deemph_switch_r});
		axi_rd(`SDDC_ADDR_STATUS, rd, rs);
		chk("deemph status", 32'h1, {31'h0, rd[`SDDC_ST_DEEMPH]});
		deemph_enable <= 1'b0;
		repeat (8) @(posedge ref_clk);
		chk("deemph off", 32'h0, {30'h0, deemph_switch_l, deemph_switch_r});
		axi_wr(`SDDC_ADDR_CTRL, 32'h1, rs);
		sleep_reset_n <= 1'b0;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (sleeping !== 1'b1 && n < 20);
		if (sleeping !== 1'b1) hang("sleep");
		repeat (8) @(posedge ref_clk);
		s0 = strobes;
		repeat (200) @(posedge ref_clk);
		chk("asleep ticks", 32'h0, strobes - s0);
		chk("asleep level", 32'h8, {27'h0, mod_level_l});
		sleep_reset_n <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (sleeping !== 1'b0 && n < 20);
		if (sleeping !== 1'b0) hang("wake");
		axi_rd(`SDDC_ADDR_CTRL, rd, rs);
		chk("ctrl after wake", 32'h0, rd);
		chk("level range", 32'h0, {31'h0, lvl_bad});
		print_verdict();
	end
endmodule
`default_nettype wire
